// File: verilog/tbfc_regs.vh
// Register map, field positions, reset values and delimiter timing of the Type B framer.
`ifndef TBFC_REGS_VH
`define TBFC_REGS_VH

// Register indices; the byte address on APB is four times the index.
`define TBFC_IDX_CONFIG 8'h1E
`define TBFC_IDX_CTRL 8'h30
`define TBFC_IDX_IRQ_STAT 8'h31
`define TBFC_IDX_IRQ_MASK 8'h32
`define TBFC_IDX_STATE 8'h33

// Framing configuration fields.
`define TBFC_CFG_RESET 8'h00
`define TBFC_CFG_WMASK 8'hDF
`define TBFC_BIT_RX_START_REQ 7
`define TBFC_BIT_RX_END_REQ 6
`define TBFC_BIT_DELIM_WIDTH 4
`define TBFC_BIT_TX_START_SUP 3
`define TBFC_BIT_TX_END_SUP 2

// Control register fields.
`define TBFC_BIT_DELIM_ADJUST 0
`define TBFC_BIT_TYPEB_MODE 1

// Interrupt status and mask fields.
`define TBFC_IRQ_RX_DONE 0
`define TBFC_IRQ_RX_DISCARD 1
`define TBFC_IRQ_PROTO_ERR 2
`define TBFC_IRQ_TX_DONE 3

// Receive symbol kinds from the decoder.
`define TBFC_SYM_DATA 2'h0
`define TBFC_SYM_START 2'h1
`define TBFC_SYM_END 2'h2

// Delimiter phase lengths in etu, and the fine adjustment in carrier cycles.
`define TBFC_SOF_LOW_MIN_ETU 10
`define TBFC_SOF_LOW_MAX_ETU 11
`define TBFC_SOF_HIGH_MIN_ETU 2
`define TBFC_SOF_HIGH_MAX_ETU 3
`define TBFC_EOF_LOW_MIN_ETU 10
`define TBFC_EOF_LOW_MAX_ETU 11
`define TBFC_ADJ_LOW_ETU 11
`define TBFC_ADJ_HIGH_ETU 2
`define TBFC_ADJ_FC 8
`define TBFC_ETU_FC 128

`endif

// File: verilog/tbfc_tx_framer.v
// Type B transmit sequencer: start delimiter, characters with guard time, end delimiter.
`timescale 1ns/1ps
`include "tbfc_regs.vh"

module tbfc_tx_framer #(
    parameter ETU_FC = `TBFC_ETU_FC
) (
    input wire clk_sys,
    input wire rst_n,
    input wire fc_tick,
    input wire frame_start,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire byte_last,
    output wire byte_ready,
    input wire sof_en,
    input wire eof_en,
    input wire [1:0] egt_len,
    input wire width_sel,
    input wire adjust_sel,
    output reg tx_mod,
    output wire busy,
    output reg done
);

    localparam S_IDLE = 3'd0;
    localparam S_SOFL = 3'd1;
    localparam S_SOFH = 3'd2;
    localparam S_WAITB = 3'd3;
    localparam S_BITS = 3'd4;
    localparam S_EGT = 3'd5;
    localparam S_EOFL = 3'd6;

    reg [2:0] state_q;
    reg [11:0] cnt_q;
    reg [9:0] shf_q;
    reg [3:0] nbit_q;
    reg last_q;

    // Length in carrier cycles of a phase of n etu, trimmed by plus or minus the adjust amount.
    function [11:0] fc_len;
        input [31:0] etu;
        input adj;
        input up;
        reg [31:0] base;
        begin
            base = etu * ETU_FC;
            if (adj && up) begin
                base = base + `TBFC_ADJ_FC;
            end else if (adj) begin
                base = base - `TBFC_ADJ_FC;
            end
            fc_len = base[11:0];
        end
    endfunction

    // Low phase of either delimiter; adjust mode overrides the width choice.
    wire [11:0] low_len = adjust_sel ? fc_len(`TBFC_ADJ_LOW_ETU, 1'b1, 1'b0) :
        width_sel ? fc_len(`TBFC_SOF_LOW_MAX_ETU, 1'b0, 1'b0) :
        fc_len(`TBFC_SOF_LOW_MIN_ETU, 1'b0, 1'b0);
    wire [11:0] high_len = adjust_sel ? fc_len(`TBFC_ADJ_HIGH_ETU, 1'b1, 1'b1) :
        width_sel ? fc_len(`TBFC_SOF_HIGH_MAX_ETU, 1'b0, 1'b0) :
        fc_len(`TBFC_SOF_HIGH_MIN_ETU, 1'b0, 1'b0);
    wire [11:0] etu_len = fc_len(32'd1, 1'b0, 1'b0);
    wire phase_end = fc_tick && (cnt_q == 12'h001);

    // The byte hand-over costs one clk_sys cycle in S_WAITB; it stays hidden between
    // carrier ticks only while fc_tick never comes on two clocks in a row.
    assign byte_ready = (state_q == S_WAITB);
    assign busy = (state_q != S_IDLE);

    // Sequencer; each phase counts carrier ticks down to one and then moves on.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            cnt_q <= 12'h000;
            shf_q <= 10'h3FF;
            nbit_q <= 4'h0;
            last_q <= 1'b0;
            tx_mod <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (fc_tick && cnt_q != 12'h000) begin
                cnt_q <= cnt_q - 12'h001;
            end
            case (state_q)
                S_IDLE: begin
                    tx_mod <= 1'b1;
                    if (frame_start && sof_en) begin
                        state_q <= S_SOFL;
                        cnt_q <= low_len;
                        tx_mod <= 1'b0;
                    end else if (frame_start) begin
                        state_q <= S_WAITB;
                    end
                end
                S_SOFL: begin
                    if (phase_end) begin
                        state_q <= S_SOFH;
                        cnt_q <= high_len;
                        tx_mod <= 1'b1;
                    end
                end
                S_SOFH: begin
                    if (phase_end) begin
                        state_q <= S_WAITB;
                    end
                end
                S_WAITB: begin
                    if (byte_valid) begin
                        shf_q <= {1'b1, byte_data[7:0], 1'b0};
                        last_q <= byte_last;
                        nbit_q <= 4'd10;
                        cnt_q <= etu_len;
                        tx_mod <= 1'b0;
                        state_q <= S_BITS;
                    end
                end
                S_BITS: begin
                    if (phase_end && nbit_q != 4'd1) begin
                        nbit_q <= nbit_q - 4'd1;
                        shf_q <= {1'b1, shf_q[9:1]};
                        tx_mod <= shf_q[1];
                        cnt_q <= etu_len;
                    end else if (phase_end && !last_q && egt_len != 2'b00) begin
                        state_q <= S_EGT;
                        cnt_q <= fc_len({30'h00000000, egt_len}, 1'b0, 1'b0);
                        tx_mod <= 1'b1;
                    end else if (phase_end && !last_q) begin
                        state_q <= S_WAITB;
                        tx_mod <= 1'b1;
                    end else if (phase_end && eof_en) begin
                        state_q <= S_EOFL;
                        cnt_q <= low_len;
                        tx_mod <= 1'b0;
                    end else if (phase_end) begin
                        state_q <= S_IDLE;
                        tx_mod <= 1'b1;
                        done <= 1'b1;
                    end
                end
                S_EGT: begin
                    if (phase_end) begin
                        state_q <= S_WAITB;
                    end
                end
                S_EOFL: begin
                    if (phase_end) begin
                        state_q <= S_IDLE;
                        tx_mod <= 1'b1;
                        done <= 1'b1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // tbfc_tx_framer

// File: verilog/tbfc_top.v
// Type B frame control: APB registers, receive delimiter filter, interrupts and transmit framer.
//
// Functional notes
// - With start required set, a receive stream that does not open with a start delimiter is dropped.
// - With start required clear, streams with or without a start delimiter pass, minus the delimiter.
// - With end required set, a stream that ends without an end delimiter flags a protocol error.
// - With end required clear, streams with or without an end delimiter pass, minus the delimiter.
// - Width set and adjust clear gives the longest start and end delimiters.
// - Width clear and adjust clear gives the shortest start and end delimiters.
// - Width and adjust both set give low phases of 11 etu less 8 cycles, start high 2 etu plus 8.
// - Start suppress set sends frames with no start delimiter.
// - End suppress set sends frames with no end delimiter.
// - The two guard bits add zero to three etu of extra guard time.
// - The framing configuration register sits at index 1E and resets to zero.
// - Bit 5 of the framing configuration reads zero and does nothing.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tbfc_regs.vh"

module tbfc_top #(
    parameter ETU_FC = `TBFC_ETU_FC
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output wire irq,
    input wire rx_sym_valid,
    input wire [1:0] rx_sym_kind,
    input wire [7:0] rx_sym_data,
    input wire rx_stream_end,
    output reg fifo_wr_valid,
    output reg [7:0] fifo_wr_data,
    input wire fc_tick,
    input wire tx_frame_start,
    input wire tx_byte_valid,
    input wire [7:0] tx_byte_data,
    input wire tx_byte_last,
    output wire tx_byte_ready,
    output wire tx_mod,
    output wire tx_busy
);

    localparam RX_IDLE = 2'd0;
    localparam RX_PASS = 2'd1;
    localparam RX_DROP = 2'd2;

    reg [7:0] cfg_q;
    reg [1:0] ctrl_q;
    reg [3:0] stat_q;
    reg [3:0] stat_d;
    reg [3:0] mask_q;
    reg [1:0] rx_state_q;
    reg rx_end_seen_q;
    reg ev_rx_done;
    reg ev_rx_discard;
    reg ev_proto_err;
    wire ev_tx_done;

    // The byte address carries the register index in bits 7:2; the low bits must be zero.
    function hit;
        input [7:0] addr;
        input [7:0] idx;
        begin
            hit = (addr[1:0] == 2'b00) && ({2'b00, addr[7:2]} == idx);
        end
    endfunction

    // Fields of the configuration, gated so that nothing acts outside Type B mode.
    wire typeb_mode = ctrl_q[`TBFC_BIT_TYPEB_MODE];
    wire delimiter_adjust_sel = ctrl_q[`TBFC_BIT_DELIM_ADJUST];
    wire rx_start_required = typeb_mode && cfg_q[`TBFC_BIT_RX_START_REQ];
    wire rx_end_required = typeb_mode && cfg_q[`TBFC_BIT_RX_END_REQ];
    wire delimiter_width_sel = cfg_q[`TBFC_BIT_DELIM_WIDTH];
    wire tx_start_suppress = cfg_q[`TBFC_BIT_TX_START_SUP];
    wire tx_end_suppress = cfg_q[`TBFC_BIT_TX_END_SUP];
    wire [1:0] tx_extra_guard_len = typeb_mode ? cfg_q[1:0] : 2'b00;

    // Access strobes; a write lands in the access phase, once per transfer.
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire wr_cfg = apb_wr && hit(paddr, `TBFC_IDX_CONFIG);
    wire wr_ctrl = apb_wr && hit(paddr, `TBFC_IDX_CTRL);
    wire wr_stat = apb_wr && hit(paddr, `TBFC_IDX_IRQ_STAT);
    wire wr_mask = apb_wr && hit(paddr, `TBFC_IDX_IRQ_MASK);
    wire mapped = hit(paddr, `TBFC_IDX_CONFIG) || hit(paddr, `TBFC_IDX_CTRL) ||
        hit(paddr, `TBFC_IDX_IRQ_STAT) || hit(paddr, `TBFC_IDX_IRQ_MASK) ||
        hit(paddr, `TBFC_IDX_STATE);

    // The slave never stalls: read data is staged in the setup cycle.
    assign pready = 1'b1;

    // Software-written registers.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `TBFC_CFG_RESET;
            ctrl_q <= 2'b00;
            mask_q <= 4'h0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= pwdata[7:0] & `TBFC_CFG_WMASK;
            end
            if (wr_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[3:0];
            end
        end
    end

    // Sticky event bits: write one to clear, and a new event in the same cycle wins.
    always @* begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_d & ~pwdata[3:0];
        end
        stat_d = stat_d | {ev_tx_done, ev_proto_err, ev_rx_discard, ev_rx_done};
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 4'h0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // One level interrupt, high while any unmasked event is pending.
    assign irq = |(stat_q & mask_q);

    // Read data and error answer, captured in the setup cycle and held through the access.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= !mapped;
            if (hit(paddr, `TBFC_IDX_CONFIG)) begin
                prdata <= {24'h000000, cfg_q};
            end else if (hit(paddr, `TBFC_IDX_CTRL)) begin
                prdata <= {30'h00000000, ctrl_q};
            end else if (hit(paddr, `TBFC_IDX_IRQ_STAT)) begin
                prdata <= {28'h0000000, stat_q};
            end else if (hit(paddr, `TBFC_IDX_IRQ_MASK)) begin
                prdata <= {28'h0000000, mask_q};
            end else if (hit(paddr, `TBFC_IDX_STATE)) begin
                prdata <= {28'h0000000, rx_end_seen_q, rx_state_q == RX_DROP,
                    rx_state_q == RX_PASS, tx_busy};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Receive filter. The decoder sits on clk_sys, so its symbols need no synchroniser.
    // Delimiters never reach the FIFO; whether a stream is kept is settled by its
    // first symbol, which is why a late start delimiter cannot rescue a dropped stream.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_end_seen_q <= 1'b0;
            fifo_wr_valid <= 1'b0;
            fifo_wr_data <= 8'h00;
            ev_rx_done <= 1'b0;
            ev_rx_discard <= 1'b0;
            ev_proto_err <= 1'b0;
        end else begin
            fifo_wr_valid <= 1'b0;
            ev_rx_done <= 1'b0;
            ev_rx_discard <= 1'b0;
            ev_proto_err <= 1'b0;
            if (rx_stream_end) begin
                if (rx_state_q == RX_PASS && rx_end_required && !rx_end_seen_q) begin
                    ev_proto_err <= 1'b1;
                end
                if (rx_state_q == RX_PASS) begin
                    ev_rx_done <= 1'b1;
                end
                rx_state_q <= RX_IDLE;
                rx_end_seen_q <= 1'b0;
            end else if (rx_sym_valid) begin
                case (rx_state_q)
                    RX_IDLE: begin
                        if (rx_sym_kind == `TBFC_SYM_START) begin
                            rx_state_q <= RX_PASS;
                        end else if (rx_start_required) begin
                            rx_state_q <= RX_DROP;
                            ev_rx_discard <= 1'b1;
                        end else if (rx_sym_kind == `TBFC_SYM_END) begin
                            rx_state_q <= RX_PASS;
                            rx_end_seen_q <= 1'b1;
                        end else begin
                            rx_state_q <= RX_PASS;
                            fifo_wr_valid <= 1'b1;
                            fifo_wr_data <= rx_sym_data;
                        end
                    end
                    RX_PASS: begin
                        if (rx_sym_kind == `TBFC_SYM_END) begin
                            rx_end_seen_q <= 1'b1;
                        end else if (rx_sym_kind == `TBFC_SYM_DATA) begin
                            fifo_wr_valid <= 1'b1;
                            fifo_wr_data <= rx_sym_data;
                        end
                    end
                    RX_DROP: begin
                        rx_state_q <= RX_DROP;
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Transmit sequencer. Outside Type B mode both delimiters are left out.
    // A width-clear, adjust-set setting is taken as adjust timing; software avoids it.
    tbfc_tx_framer #(
        .ETU_FC(ETU_FC)
    ) u_tx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fc_tick(fc_tick),
        .frame_start(tx_frame_start),
        .byte_valid(tx_byte_valid),
        .byte_data(tx_byte_data),
        .byte_last(tx_byte_last),
        .byte_ready(tx_byte_ready),
        .sof_en(typeb_mode && !tx_start_suppress),
        .eof_en(typeb_mode && !tx_end_suppress),
        .egt_len(tx_extra_guard_len),
        .width_sel(delimiter_width_sel),
        .adjust_sel(delimiter_adjust_sel),
        .tx_mod(tx_mod),
        .busy(tx_busy),
        .done(ev_tx_done)
    );

endmodule // tbfc_top

// File: tb/tbfc_top_properties.sv
// Port-level concurrent checks for the Type B framer top.
`timescale 1ns/1ps
`include "tbfc_regs.vh"

module tbfc_top_properties #(
    parameter ETU_FC = `TBFC_ETU_FC
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_sym_valid,
    input wire [1:0] rx_sym_kind,
    input wire [7:0] rx_sym_data,
    input wire fifo_wr_valid,
    input wire [7:0] fifo_wr_data,
    input wire fc_tick,
    input wire tx_mod,
    input wire tx_byte_ready,
    input wire tx_busy
);
    reg [15:0] low_cnt_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Carrier ticks of the current low run; cleared while high so each run starts afresh.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 16'h0000;
        end else if (tx_mod) begin
            low_cnt_q <= 16'h0000;
        end else if (fc_tick) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    sequence misalign_s;
        psel && !penable && paddr[1:0] != 2'h0 ##1 psel && penable;
    endsequence
    sequence cfg_read_s;
        psel && penable && paddr == 8'h78;
    endsequence

    pready_high_a: assert property (pready) else $error("pready low");
    align_err_a: assert property (misalign_s |-> pslverr) else $error("no slave error");
    cfg_zero_a: assert property (cfg_read_s |-> prdata[31:8] == 24'h000000 && !prdata[5])
        else $error("config reads a reserved one");
    delim_drop_a: assert property (rx_sym_valid && rx_sym_kind != `TBFC_SYM_DATA
        |=> !fifo_wr_valid) else $error("delimiter reached fifo");
    fifo_cause_a: assert property (fifo_wr_valid |-> $past(rx_sym_valid)
        && $past(rx_sym_kind) == `TBFC_SYM_DATA) else $error("fifo write without data");
    fifo_data_a: assert property (fifo_wr_valid |-> fifo_wr_data == $past(rx_sym_data))
        else $error("fifo data differs");
    low_busy_a: assert property ($fell(tx_mod) |-> tx_busy) else $error("low while idle");
    low_min_a: assert property ($rose(tx_mod) |-> low_cnt_q >= ETU_FC)
        else $error("low run too short");
    low_max_a: assert property ($rose(tx_mod) |-> low_cnt_q <= 11 * ETU_FC)
        else $error("low run too long");
    ready_busy_a: assert property (tx_byte_ready |-> tx_busy) else $error("ready while idle");
endmodule // tbfc_top_properties

bind tbfc_top tbfc_top_properties #(.ETU_FC(ETU_FC)) u_tbfc_top_properties (.clk_sys, .rst_n,
    .paddr, .psel, .penable, .prdata, .pready, .pslverr, .rx_sym_valid, .rx_sym_kind,
    .rx_sym_data, .fifo_wr_valid, .fifo_wr_data, .fc_tick, .tx_mod, .tx_byte_ready, .tx_busy);

// File: tb/tbfc_card.sv
// Card-side model: sends receive symbols and records the reader line as level runs.
`timescale 1ns/1ps

module tbfc_card (
    input wire clk_sys,
    input wire tx_mod,
    output reg fc_tick,
    output reg rx_sym_valid,
    output reg [1:0] rx_sym_kind,
    output reg [7:0] rx_sym_data,
    output reg rx_stream_end
);
    int runs[$];
    int run_len;
    reg last_mod;
    reg [1:0] div_q = 2'h0;

    initial begin
        fc_tick = 1'b0;
        rx_sym_valid = 1'b0;
        rx_sym_kind = 2'h3;
        rx_sym_data = 8'h00;
        rx_stream_end = 1'b0;
        run_len = 0;
        last_mod = 1'b1;
    end

    // A carrier tick on every third clock, near the real carrier-to-clock ratio; a tick on
    // every clock would turn the framer's one-cycle byte hand-over into a carrier period.
    always @(posedge clk_sys) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        fc_tick <= (div_q == 2'h2);
    end

    // Each finished run is stored as twice its length in carrier ticks plus its level.
    always @(posedge clk_sys) begin
        if (tx_mod !== last_mod) begin
            runs.push_back(2 * run_len + last_mod);
            run_len = 0;
        end
        if (fc_tick === 1'b1) begin
            run_len++;
        end
        last_mod = tx_mod;
    end

    // Released lines carry the inverse so a stale value is never mistaken for data.
    task send_sym(input [1:0] k, input [7:0] d);
        @(posedge clk_sys);
        rx_sym_valid <= 1'b1;
        rx_sym_kind <= k;
        rx_sym_data <= d;
        @(posedge clk_sys);
        rx_sym_valid <= 1'b0;
        rx_sym_kind <= ~k;
        rx_sym_data <= ~d;
    endtask

    task end_stream;
        @(posedge clk_sys);
        rx_stream_end <= 1'b1;
        @(posedge clk_sys);
        rx_stream_end <= 1'b0;
    endtask
endmodule // tbfc_card

// File: tb/typeb_frame_control_test.sv
// Directed bench for the Type B framer: registers, receive filter, interrupt, transmit timing.
`timescale 1ns/1ps
`include "tbfc_regs.vh"

module typeb_frame_control_test;
    localparam int ETU = 16;
    localparam [7:0] A_CFG = `TBFC_IDX_CONFIG * 4;
    localparam [7:0] A_CTRL = `TBFC_IDX_CTRL * 4;
    localparam [7:0] A_STAT = `TBFC_IDX_IRQ_STAT * 4;
    localparam [7:0] A_MASK = `TBFC_IDX_IRQ_MASK * 4;
    reg clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00, tx_byte_data = 8'h00, fifo_last, b;
    reg [31:0] pwdata = 32'h0, r;
    reg tx_frame_start = 1'b0, tx_byte_valid = 1'b0, tx_byte_last = 1'b0, e;
    wire [31:0] prdata;
    wire [7:0] fifo_wr_data, rx_sym_data;
    wire [1:0] rx_sym_kind;
    wire pready, pslverr, irq, fifo_wr_valid, fc_tick, rx_sym_valid, rx_stream_end;
    wire tx_byte_ready, tx_mod, tx_busy;
    int n_fail = 0, n_checks = 0, fifo_n = 0, exp_runs[$];
    reg [9:0] txt[5] = '{10'h210, 10'h201, 10'h312, 10'h20F, 10'h013};
    reg [7:0] rxt[6] = '{8'h9C, 8'hC9, 8'h84, 8'hB6, 8'hFC, 8'h64};

    always #12.5 clk_sys = ~clk_sys;

    // Count what reaches the receive fifo.
    always @(posedge clk_sys) begin
        if (fifo_wr_valid === 1'b1) begin
            fifo_n++;
            fifo_last = fifo_wr_data;
        end
    end

    tbfc_top #(.ETU_FC(ETU)) u_tbfc_top (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .rx_sym_valid(rx_sym_valid),
        .rx_sym_kind(rx_sym_kind), .rx_sym_data(rx_sym_data), .rx_stream_end(rx_stream_end),
        .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data), .fc_tick(fc_tick),
        .tx_frame_start(tx_frame_start), .tx_byte_valid(tx_byte_valid),
        .tx_byte_data(tx_byte_data), .tx_byte_last(tx_byte_last),
        .tx_byte_ready(tx_byte_ready), .tx_mod(tx_mod), .tx_busy(tx_busy));
    tbfc_card u_tbfc_card (.clk_sys(clk_sys), .tx_mod(tx_mod), .fc_tick(fc_tick),
        .rx_sym_valid(rx_sym_valid), .rx_sym_kind(rx_sym_kind), .rx_sym_data(rx_sym_data),
        .rx_stream_end(rx_stream_end));

    task check(input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // A spent bound counts as a mismatch and ends the run.
    task bound(input int i);
        if (i >= 4000) begin
            n_fail++;
            print_verdict;
        end
    endtask

    // One APB transfer; request held until pready is sampled high.
    task apb(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output er);
        int i;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge clk_sys); i++; end while (pready !== 1'b1 && i < 4000);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bound(i);
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    // Expected line as runs; a run of the same level as the last one extends it.
    task seg(input l, input int n);
        if (n == 0) return;
        if (exp_runs.size() > 0 && exp_runs[$] % 2 == l) exp_runs[$] += 2 * n;
        else exp_runs.push_back(2 * n + l);
    endtask

    task give(input [7:0] d, input last);
        int i;
        {tx_byte_valid, tx_byte_data, tx_byte_last} <= {1'b1, d, last};
        i = 0;
        do begin @(posedge clk_sys); i++; end while (tx_byte_ready !== 1'b1 && i < 4000);
        bound(i);
    endtask

    // Two-byte frame, second byte all ones, line compared run by run.
    task tx_frame(input [9:0] t);
        int i, lo, hi;
        reg [7:0] c;
        c = t[9] ? t[7:0] : 8'h0C;
        wr(A_CTRL, {30'h0, t[9], 1'b0});
        wr(A_CFG, t[7:0]);
        wr(A_CTRL, {30'h0, t[9:8]});
        lo = t[8] ? 11 * ETU - 8 : (c[4] ? 11 : 10) * ETU;
        hi = t[8] ? 2 * ETU + 8 : (c[4] ? 3 : 2) * ETU;
        exp_runs.delete();
        if (!c[3]) begin seg(0, lo); seg(1, hi); end
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'hFF : 8'h35;
            seg(0, ETU);
            for (int j = 0; j < 8; j++) seg(b[j], ETU);
            seg(1, ETU);
            if (k == 0 && t[9]) seg(1, t[1:0] * ETU);
        end
        if (!c[2]) seg(0, lo);
        if (exp_runs[$] % 2 == 1) exp_runs.pop_back();
        u_tbfc_card.runs.delete();
        @(posedge clk_sys);
        tx_frame_start <= 1'b1;
        @(posedge clk_sys);
        tx_frame_start <= 1'b0;
        give(8'h35, 1'b0);
        give(8'hFF, 1'b1);
        tx_byte_valid <= 1'b0;
        i = 0;
        do begin @(posedge clk_sys); i++; end while (tx_busy !== 1'b0 && i < 4000);
        bound(i);
        repeat (3) @(posedge clk_sys);
        check(u_tbfc_card.runs.size(), exp_runs.size() + 1);
        for (i = 0; i < exp_runs.size() && i + 1 < u_tbfc_card.runs.size(); i++)
            check(u_tbfc_card.runs[i + 1], exp_runs[i]);
        $display("tx test %h done", t);
    endtask

    // Receive stream per table row, then status, interrupt and clear.
    task rx_row(input [7:0] t, input [7:0] d);
        wr(A_CTRL, {30'h0, t[7], 1'b0});
        wr(A_CFG, {t[6:5], 6'h00});
        wr(A_STAT, 32'hF);
        fifo_n = 0;
        if (t[4]) u_tbfc_card.send_sym(`TBFC_SYM_START, 8'h00);
        u_tbfc_card.send_sym(`TBFC_SYM_DATA, d);
        if (t[3]) u_tbfc_card.send_sym(`TBFC_SYM_END, 8'h00);
        u_tbfc_card.end_stream;
        repeat (4) @(posedge clk_sys);
        check(fifo_n, t[2]);
        if (t[2]) check(fifo_last, d);
        apb(1'b0, A_STAT, 32'h0, r, e);
        check(r & 32'h6, {t[1:0], 1'b0});
        check(irq, t[1]);
        wr(A_STAT, 32'hF);
        @(posedge clk_sys);
        check(irq, 1'b0);
        $display("rx test %h done", t);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, A_CFG, 32'h0, r, e);
        check(r, 32'h00);
        wr(A_CFG, 32'hFF);
        apb(1'b0, A_CFG, 32'h0, r, e);
        check(r, 32'hDF);
        apb(1'b0, 8'h7C, 32'h0, r, e);
        check(e, 1'b1);
        apb(1'b1, 8'h79, 32'h0, r, e);
        check(e, 1'b1);
        $display("register test done");
        wr(A_MASK, 32'h4);
        for (int i = 0; i < 6; i++) rx_row(rxt[i], 8'hA0 + i);
        for (int i = 0; i < 5; i++) tx_frame(txt[i]);
        print_verdict;
    end
endmodule // typeb_frame_control_test
